//--- event_alarm_regs.svh
`ifndef EVENT_ALARM_REGS_SVH
`define EVENT_ALARM_REGS_SVH

// Register byte offsets
`define EA_CMD_OFS 12'h000
`define EA_INPUTS_OFS 12'h004
`define EA_TALLY_OFS 12'h008
`define EA_TALLY_FZ_OFS 12'h00C
`define EA_CEIL_OFS 12'h010
`define EA_BOTTOM_OFS 12'h014
`define EA_DOUT_OFS 12'h018
`define EA_STATUS_OFS 12'h01C

// Command register bits (write one to act)
`define EA_CMD_ROUTE_ON 0
`define EA_CMD_ROUTE_OFF 1
`define EA_CMD_LATCH_CLEAR 2
`define EA_CMD_TALLY_ZERO 3
`define EA_CMD_REMOTE_RESET 4

// Limit registers: signed value in low bits, mode in bit 31
`define EA_LIMIT_MODE_BIT 31

// Status register bits
`define EA_STAT_ROUTE 0
`define EA_STAT_BOTTOM_ALARM 1
`define EA_STAT_CEIL_ALARM 2
`define EA_STAT_TALLY_FULL 3

// Reset values of the retained settings
`define EA_ROUTE_RESET 1'b0
`define EA_LIMIT_RESET 32'h0000_0000

// Timing and counting
`define EA_DEBOUNCE_MS 10
`define EA_CLK_HZ 20000000
`define EA_TALLY_MAX 24'h98967F

`endif

//--- event_alarm_pkg.sv
`default_nettype none
package event_alarm_pkg;
  typedef enum logic {
    ALARM_MOMENTARY = 1'b0,
    ALARM_LATCHING = 1'b1
  } alarm_mode_type;
endpackage
`default_nettype wire

//--- event_counter_alarm_logic.sv
`include "event_alarm_regs.svh"
`default_nettype none
// Contract
// - Unconnected inputs read 1 via external pull-up; grounded inputs read 0.
// - Input-read returns current input states; no command alters them.
// - Event counter counts pulses taken from digital input 0.
// - Counting input is debounced: one count per mechanical closure.
// - Counter saturates at 9,999,999 and never wraps.
// - Count fetch returns the count without changing it.
// - Tally-zero clears count; fetch-and-zero returns then clears atomically.
// - Count is volatile and zero after power-up.
// - Remote reset and line break leave the count unchanged.
// - Route-on makes the two shared pins follow alarms; others unaffected.
// - Route-off gives the shared pins back to the output-write command.
// - Upper and lower limits are retained across power removal; this model resets them to 0 on presetn.
// - Each limit write also records momentary or latching mode.
// - Momentary alarm active exactly while its limit condition holds.
// - Latching alarm stays active after input returns within limits.
// - Latch-clear command deactivates any latched alarm.
// - Upper alarm asserts when reading strictly exceeds upper limit.
// - Lower alarm asserts when reading strictly below lower limit.
// - Both stored limits can be fetched at any time.
// - Latched lower alarm releases when reading exceeds the upper limit.
// - With both alarms latching, upper alarm is complement of lower.
// - Alarm-or-output routing of shared pins is retained across power loss; this model resets it to off on presetn.
// - Outputs off after power loss until an output-write switches them.
// - Limits compare against sensor reading plus output offset.
module event_counter_alarm_logic #(
  parameter int NUM_DIN = 8,
  parameter int NUM_DOUT = 8,
  parameter int DATA_W = 28,
  parameter int DEBOUNCE_CYCLES = `EA_DEBOUNCE_MS * (`EA_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Digital input pins, bit 0 is tally_input_pin
  input wire logic [NUM_DIN-1:0] din,
  // Open-drain outputs: bit 0 bottom_alarm_pin, bit 1 ceiling_alarm_pin
  output logic [NUM_DOUT-1:0] dout_o,
  output logic [NUM_DOUT-1:0] dout_oe,
  // Sensor reading path
  input wire logic signed [DATA_W-1:0] reading,
  input wire logic signed [DATA_W-1:0] reading_offset,
  input wire logic reading_valid
);

  localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);

  logic [NUM_DIN-1:0] din_meta_q;
  logic [NUM_DIN-1:0] din_sync_q;
  logic [DEB_W-1:0] deb_cnt_q;
  logic tally_level_q;
  logic [23:0] tally_q;
  logic route_q;
  logic [NUM_DOUT-1:0] dout_q;
  logic signed [DATA_W-1:0] ceil_q;
  logic signed [DATA_W-1:0] bottom_q;
  event_alarm_pkg::alarm_mode_type ceil_mode_q;
  event_alarm_pkg::alarm_mode_type bottom_mode_q;
  logic ceil_alarm_q;
  logic bottom_alarm_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [NUM_DOUT-1:0] dout_oe_q;

  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rd_value;
  logic fall_event;
  logic zero_req;
  logic fetch_zero;
  logic [23:0] tally_left;
  logic latch_clear;
  logic signed [DATA_W:0] measured;
  logic over_ceil;
  logic under_bottom;
  logic ceil_alarm_d;
  logic bottom_alarm_d;

  // Bus handshake: no wait state; read data is registered in the setup cycle
  assign setup = psel & ~penable & ~pready_q;
  assign access = psel & penable & pready_q;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (paddr)
      `EA_CMD_OFS: rd_value = 32'h0000_0000;
      `EA_INPUTS_OFS: rd_value[NUM_DIN-1:0] = din_sync_q;
      `EA_TALLY_OFS: rd_value[23:0] = tally_q;
      `EA_TALLY_FZ_OFS: rd_value[23:0] = tally_q;
      `EA_CEIL_OFS: begin
        rd_value = {{(32 - DATA_W){ceil_q[DATA_W-1]}}, ceil_q};
        rd_value[`EA_LIMIT_MODE_BIT] = ceil_mode_q;
      end
      `EA_BOTTOM_OFS: begin
        rd_value = {{(32 - DATA_W){bottom_q[DATA_W-1]}}, bottom_q};
        rd_value[`EA_LIMIT_MODE_BIT] = bottom_mode_q;
      end
      `EA_DOUT_OFS: rd_value[NUM_DOUT-1:0] = dout_q;
      `EA_STATUS_OFS: begin
        rd_value[`EA_STAT_ROUTE] = route_q;
        rd_value[`EA_STAT_BOTTOM_ALARM] = bottom_alarm_q;
        rd_value[`EA_STAT_CEIL_ALARM] = ceil_alarm_q;
        rd_value[`EA_STAT_TALLY_FULL] = (tally_q == `EA_TALLY_MAX);
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_value;
        pslverr_q <= ~mapped;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Input synchronisers; pull-ups are on the board, so idle reads 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_meta_q <= '1;
      din_sync_q <= '1;
    end else begin
      din_meta_q <= din;
      din_sync_q <= din_meta_q;
    end
  end

  // Debounce input 0: new level accepted only after it stays put
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cnt_q <= '0;
      tally_level_q <= 1'b1;
    end else if (din_sync_q[0] == tally_level_q) begin
      deb_cnt_q <= '0;
    end else if (deb_cnt_q == DEB_W'(DEBOUNCE_CYCLES - 1)) begin
      deb_cnt_q <= '0;
      tally_level_q <= din_sync_q[0];
    end else begin
      deb_cnt_q <= deb_cnt_q + 1'b1;
    end
  end

  assign fall_event = tally_level_q & ~din_sync_q[0] &
    (deb_cnt_q == DEB_W'(DEBOUNCE_CYCLES - 1));
  assign zero_req = wr & (paddr == `EA_CMD_OFS) & pwdata[`EA_CMD_TALLY_ZERO];
  assign fetch_zero = rd & (paddr == `EA_TALLY_FZ_OFS);
  // Events counted after the setup-cycle snapshot must survive the clear
  assign tally_left = tally_q - prdata_q[23:0];

  // A clear never loses an event that lands in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tally_q <= 24'h000000;
    end else if (fetch_zero) begin
      tally_q <= tally_left + {23'h000000, fall_event};
    end else if (zero_req) begin
      tally_q <= fall_event ? 24'h000001 : 24'h000000;
    end else if (fall_event && tally_q != `EA_TALLY_MAX) begin
      tally_q <= tally_q + 24'h000001;
    end
    // Remote reset is accepted on the command word but touches no count
  end

  // Retained settings; a real part backs these with nonvolatile storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= `EA_ROUTE_RESET;
    end else if (wr && paddr == `EA_CMD_OFS) begin
      if (pwdata[`EA_CMD_ROUTE_ON]) begin
        route_q <= 1'b1;
      end else if (pwdata[`EA_CMD_ROUTE_OFF]) begin
        route_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ceil_q <= DATA_W'(`EA_LIMIT_RESET);
      bottom_q <= DATA_W'(`EA_LIMIT_RESET);
      ceil_mode_q <= event_alarm_pkg::ALARM_MOMENTARY;
      bottom_mode_q <= event_alarm_pkg::ALARM_MOMENTARY;
    end else if (wr) begin
      if (paddr == `EA_CEIL_OFS) begin
        ceil_q <= pwdata[DATA_W-1:0];
        ceil_mode_q <= event_alarm_pkg::alarm_mode_type'(pwdata[`EA_LIMIT_MODE_BIT]);
      end
      if (paddr == `EA_BOTTOM_OFS) begin
        bottom_q <= pwdata[DATA_W-1:0];
        bottom_mode_q <= event_alarm_pkg::alarm_mode_type'(pwdata[`EA_LIMIT_MODE_BIT]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q <= '0;
    end else if (wr && paddr == `EA_DOUT_OFS) begin
      dout_q <= pwdata[NUM_DOUT-1:0];
    end
  end

  // Alarm evaluation on the offset-corrected reading
  assign measured = reading + reading_offset;
  assign over_ceil = measured > $signed({ceil_q[DATA_W-1], ceil_q});
  assign under_bottom = measured < $signed({bottom_q[DATA_W-1], bottom_q});
  assign latch_clear = wr & (paddr == `EA_CMD_OFS) & pwdata[`EA_CMD_LATCH_CLEAR];

  always_comb begin
    ceil_alarm_d = ceil_alarm_q;
    bottom_alarm_d = bottom_alarm_q;
    // Momentary alarms keep tracking their condition through a latch clear
    if (latch_clear && ceil_mode_q == event_alarm_pkg::ALARM_LATCHING) begin
      ceil_alarm_d = 1'b0;
    end
    if (latch_clear && bottom_mode_q == event_alarm_pkg::ALARM_LATCHING) begin
      bottom_alarm_d = 1'b0;
    end
    if (reading_valid) begin
      if (bottom_mode_q == event_alarm_pkg::ALARM_MOMENTARY) begin
        bottom_alarm_d = under_bottom;
      end else if (under_bottom) begin
        bottom_alarm_d = 1'b1;
      end else if (over_ceil) begin
        bottom_alarm_d = 1'b0;
      end
      if (ceil_mode_q == event_alarm_pkg::ALARM_MOMENTARY) begin
        ceil_alarm_d = over_ceil;
      end else if (bottom_mode_q == event_alarm_pkg::ALARM_LATCHING) begin
        ceil_alarm_d = ~bottom_alarm_d;
      end else if (over_ceil) begin
        ceil_alarm_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ceil_alarm_q <= 1'b0;
      bottom_alarm_q <= 1'b0;
    end else begin
      ceil_alarm_q <= ceil_alarm_d;
      bottom_alarm_q <= bottom_alarm_d;
    end
  end

  // Pin enables: high sinks current; shared pins lag the alarm status by one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_oe_q <= '0;
    end else begin
      dout_oe_q <= dout_q;
      if (route_q) begin
        dout_oe_q[0] <= bottom_alarm_q;
        dout_oe_q[1] <= ceil_alarm_q;
      end
    end
  end

  assign dout_o = '0;
  assign dout_oe = dout_oe_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule
`default_nettype wire

//--- alarm_apb_sva.sv
`default_nettype none
module alarm_apb_sva #(
  parameter int NUM_DOUT = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Output pins
  input wire logic [NUM_DOUT-1:0] dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic unmapped = (paddr > 12'h01C) || (paddr[1:0] != 2'h0);
  wire logic rd_done = pready && !pwrite;
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready && psel && penable; endsequence
  property p_rdy_lat; s_setup |=> s_answer; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready late or early");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_err_map; pready |-> pslverr == unmapped; endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong");
  property p_rd_unmap; rd_done && unmapped |-> prdata == 32'h0; endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped data not zero");
  property p_cap;
    rd_done && paddr inside {12'h008, 12'h00C} |-> prdata <= 32'h0098967F;
  endproperty
  a_cap: assert property (p_cap) else $error("count above ceiling");
  property p_sext;
    rd_done && paddr inside {12'h010, 12'h014} |-> prdata[30:28] == {3{prdata[27]}};
  endproperty
  a_sext: assert property (p_sext) else $error("limit not sign extended");
  // Command writes may move the shared pins but never the plain outputs
  property p_keep;
    pready && pwrite && paddr == 12'h000 |=> $stable(dout_oe[NUM_DOUT-1:2])[*2];
  endproperty
  a_keep: assert property (p_keep) else $error("plain output moved");
  property p_oe_rst; $rose(presetn) |-> dout_oe == '0; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("outputs on after reset");
endmodule
`default_nettype wire

//--- apb_host_model.sv
`default_nettype none
module apb_host_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_err;
  initial begin
    last_err = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // Called just after a rising edge; leaves one idle cycle behind it
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] din = 8'hFF;
  logic [7:0] dout_o, dout_oe;
  logic signed [27:0] reading = 28'h0;
  logic signed [27:0] reading_offset = 28'h0;
  logic reading_valid = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #25 pclk = ~pclk;
  event_counter_alarm_logic #(.DEBOUNCE_CYCLES(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .reading(reading),
    .reading_offset(reading_offset), .reading_valid(reading_valid));
  apb_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    host_u.xfer(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask
  // Status lands on the valid edge, pins one edge later
  task automatic sense(input logic [27:0] r, input logic [27:0] o, input logic [7:0] exp);
    reading <= r;
    reading_offset <= o;
    reading_valid <= 1'b1;
    @(posedge pclk);
    reading_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("pins", {24'h0, dout_oe}, {24'h0, exp});
  endtask
  // One closure with a short bounce before it settles low
  task automatic tap();
    din[0] <= 1'b0;
    @(posedge pclk);
    din[0] <= 1'b1;
    repeat (2) @(posedge pclk);
    din[0] <= 1'b0;
    repeat (12) @(posedge pclk);
    din[0] <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h008, 32'h0, "tally");
    rd(12'h01C, 32'h0, "status");
    chk("pins", {24'h0, dout_oe}, 32'h0);
    chk("drive", {24'h0, dout_o}, 32'h0);
    rd(12'h004, 32'hFF, "inputs");
    chk("slverr", {31'h0, host_u.last_err}, 32'h0);
    rd(12'h020, 32'h0, "unmapped");
    chk("slverr", {31'h0, host_u.last_err}, 32'h1);
    $display("reset test done");
    repeat (3) tap();
    din <= 8'h5B;
    // Let the new levels through the two synchroniser stages
    repeat (2) @(posedge pclk);
    rd(12'h004, 32'h5B, "inputs");
    din <= 8'hFF;
    wr(12'h000, 32'h10);
    rd(12'h008, 32'h3, "tally");
    rd(12'h00C, 32'h3, "fetch zero");
    rd(12'h008, 32'h0, "tally");
    tap();
    rd(12'h008, 32'h1, "tally");
    wr(12'h000, 32'h08);
    rd(12'h008, 32'h0, "tally");
    $display("tally test done");
    wr(12'h010, 32'h64);
    wr(12'h014, 32'h0FFFFFCE);
    rd(12'h010, 32'h64, "ceiling");
    rd(12'h014, 32'h7FFFFFCE, "bottom");
    wr(12'h000, 32'h01);
    rd(12'h01C, 32'h1, "status");
    sense(28'h5A, 28'h14, 8'h02);
    sense(28'h64, 28'h0, 8'h00);
    sense(28'hFFFFFCD, 28'h0, 8'h01);
    sense(28'hFFFFFCE, 28'h0, 8'h00);
    $display("momentary test done");
    wr(12'h010, 32'h80000064);
    wr(12'h014, 32'h8FFFFFCE);
    rd(12'h014, 32'hFFFFFFCE, "bottom");
    sense(28'hFFFFFC4, 28'h0, 8'h01);
    sense(28'h0, 28'h0, 8'h01);
    sense(28'h65, 28'h0, 8'h02);
    wr(12'h000, 32'h04);
    rd(12'h01C, 32'h1, "status");
    $display("latching test done");
    wr(12'h000, 32'h02);
    wr(12'h018, 32'hA6);
    repeat (2) @(posedge pclk);
    chk("pins", {24'h0, dout_oe}, 32'hA6);
    sense(28'hFFFFFC4, 28'h0, 8'hA6);
    wr(12'h000, 32'h01);
    repeat (2) @(posedge pclk);
    chk("pins", {24'h0, dout_oe}, 32'hA5);
    $display("routing test done");
    print_verdict();
  end
endmodule
bind event_counter_alarm_logic alarm_apb_sva #(.NUM_DOUT(NUM_DOUT)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dout_oe(dout_oe));
`default_nettype wire
